//--- hdl/eiea_edge_detect.sv
// valid edge detection for the eight external request inputs
// assumes the inputs are already synchronous to i_clk
`timescale 1ns/1ps
module eiea_edge_detect
  import eiea_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic [NUM_EXT-1:0] i_pins,
  input  wire logic [NUM_EXT-1:0] i_rise,
  input  wire logic [NUM_EXT-1:0] i_fall,
  output logic      [NUM_EXT-1:0] o_edge
);
  logic [NUM_EXT-1:0] prev;
  logic               primed;

  // first cycle after reset only loads, so a high pin at reset is no edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev   <= '0;
      primed <= 1'b0;
    end else begin
      prev   <= i_pins;
      primed <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_edge <= '0;
    end else if (primed) begin
      o_edge <= (i_rise & i_pins & ~prev) | (i_fall & ~i_pins & prev);
    end else begin
      o_edge <= '0;
    end
  end
endmodule // eiea_edge_detect

//--- hdl/eiea_top.sv
// edge select registers, status word and interrupt acknowledge sequencer
// assumes the core pulses i_instr_end at each boundary and pushes what o_stack_wr offers
`timescale 1ns/1ps
module eiea_top
  import eiea_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic [NUM_EXT-1:0] i_ext_pins,
  input  wire logic [NUM_EXT-1:0] i_mask_flag,
  input  wire logic [NUM_EXT-1:0] i_priority_flag,
  input  wire logic [NUM_EXT-1:0] i_req_clr,
  input  wire logic               i_mem_wr,
  input  wire logic               i_mem_rd,
  input  wire logic [15:0]        i_mem_addr,
  input  wire logic [7:0]         i_mem_wdata,
  input  wire logic               i_mem_bit_op,
  input  wire logic               i_mem_bit_val,
  input  wire logic [2:0]         i_mem_bit_idx,
  input  wire logic               i_psw_wr,
  input  wire logic [7:0]         i_psw_wdata,
  input  wire logic               i_psw_bit_op,
  input  wire logic               i_psw_bit_val,
  input  wire logic [2:0]         i_psw_bit_idx,
  input  wire logic               i_enable_irq_op,
  input  wire logic               i_disable_irq_op,
  input  wire logic               i_soft_trap_op,
  input  wire logic               i_irq_return_op,
  input  wire logic               i_trap_return_op,
  input  wire logic               i_push_status_op,
  input  wire logic               i_pop_status_op,
  input  wire logic [7:0]         i_pop_data,
  input  wire logic               i_instr_end,
  input  wire logic               i_div_busy,
  input  wire logic [15:0]        i_pc,
  output logic      [7:0]         o_mem_rdata,
  output logic      [7:0]         o_psw,
  output logic      [NUM_EXT-1:0] o_request_flag,
  output logic                    o_stack_wr,
  output logic      [7:0]         o_stack_data,
  output logic                    o_vector_load,
  output logic      [15:0]        o_vector_addr,
  output logic                    o_busy
);
  logic [7:0]         rise_sel;
  logic [7:0]         fall_sel;
  logic [NUM_EXT-1:0] edge_hit;
  logic [AGE_W-1:0]   age [NUM_EXT];
  eiea_state_type     state;
  logic               trap_pending;
  logic               trap_active;
  logic               after_return;
  logic [15:0]        pc_hold;
  logic [15:0]        vec_hold;
  logic [2:0]         win_idx;
  logic               win_any;
  logic               win_ready;
  logic               ack_go;
  logic               trap_go;
  logic [7:0]         next_psw;

  // fixed order: lowest index wins inside a level; level 0 searched first
  function automatic logic [3:0] pick(input logic [NUM_EXT-1:0] cand);
    logic [3:0] res;
    res = 4'h0;
    for (int i = NUM_EXT - 1; i >= 0; i--) begin
      if (cand[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] bit_write(input logic [7:0] val, input logic [2:0] idx,
                                           input logic bv);
    logic [7:0] res;
    res      = val;
    res[idx] = bv;
    return res;
  endfunction

  eiea_edge_detect u_edge (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_pins  (i_ext_pins),
    .i_rise  (rise_sel),
    .i_fall  (fall_sel),
    .o_edge  (edge_hit)
  );

  // edge select registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rise_sel <= EDGE_SEL_RESET;
      fall_sel <= EDGE_SEL_RESET;
    end else if (i_mem_wr && i_mem_addr == ADDR_RISE_SEL) begin
      rise_sel <= i_mem_bit_op ? bit_write(rise_sel, i_mem_bit_idx, i_mem_bit_val)
                               : i_mem_wdata;
    end else if (i_mem_wr && i_mem_addr == ADDR_FALL_SEL) begin
      fall_sel <= i_mem_bit_op ? bit_write(fall_sel, i_mem_bit_idx, i_mem_bit_val)
                               : i_mem_wdata;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_mem_rdata <= 8'h00;
    end else if (i_mem_rd) begin
      case (i_mem_addr)
        ADDR_RISE_SEL: o_mem_rdata <= rise_sel;
        ADDR_FALL_SEL: o_mem_rdata <= fall_sel;
        default:       o_mem_rdata <= 8'h00;
      endcase
    end
  end

  // winner selection among eligible requests
  always_comb begin
    logic [NUM_EXT-1:0] elig;
    logic [NUM_EXT-1:0] hi;
    logic [3:0]         p_hi;
    logic [3:0]         p_all;
    elig    = o_request_flag & ~i_mask_flag;
    hi      = elig & ~i_priority_flag;
    if (!o_psw[PSW_ISP_BIT]) begin
      elig = hi;
    end
    p_hi    = pick(hi);
    p_all   = pick(elig);
    win_any = p_all[3];
    win_idx = p_hi[3] ? p_hi[2:0] : p_all[2:0];
    win_ready = win_any
             && age[win_idx] >= (i_priority_flag[win_idx] ? LEAD_LO : LEAD_HI);
  end

  // boundary only, not mid divide, not right after a return
  assign ack_go  = state == ST_IDLE && !trap_pending && win_ready && o_psw[PSW_IE_BIT]
                && i_instr_end && !i_div_busy && !after_return;
  assign trap_go = state == ST_IDLE && trap_pending;

  // request flags: a new edge beats any clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_request_flag <= '0;
    end else begin
      for (int i = 0; i < NUM_EXT; i++) begin
        if (edge_hit[i]) begin
          o_request_flag[i] <= 1'b1;
        end else if (i_req_clr[i] || (ack_go && win_idx == 3'(i))) begin
          o_request_flag[i] <= 1'b0;
        end
      end
    end
  end

  // age of each pending request, saturating; cleared while not pending or on a new edge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_EXT; i++) begin
        age[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_EXT; i++) begin
        if (!o_request_flag[i] || edge_hit[i]) begin
          age[i] <= '0;
        end else if (age[i] != AGE_MAX) begin
          age[i] <= age[i] + 6'h01;
        end
      end
    end
  end

  // trap latched so one raised mid-sequence is not dropped
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      trap_pending <= 1'b0;
    end else if (i_soft_trap_op) begin
      trap_pending <= 1'b1;
    end else if (trap_go) begin
      trap_pending <= 1'b0;
    end
  end

  // one main instruction must end after a return before a new acknowledge
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      after_return <= 1'b0;
    end else if (i_irq_return_op || i_trap_return_op) begin
      after_return <= 1'b1;
    end else if (i_instr_end) begin
      after_return <= 1'b0;
    end
  end

  // status word; acknowledge has priority over software updates
  always_comb begin
    next_psw = o_psw;
    if (i_enable_irq_op) begin
      next_psw[PSW_IE_BIT] = 1'b1;
    end
    if (i_disable_irq_op) begin
      next_psw[PSW_IE_BIT] = 1'b0;
    end
    if (i_psw_bit_op) begin
      next_psw = bit_write(o_psw, i_psw_bit_idx, i_psw_bit_val);
    end
    if (i_psw_wr) begin
      next_psw = i_psw_wdata;
    end
    if (i_irq_return_op || i_trap_return_op || i_pop_status_op) begin
      next_psw = i_pop_data;
    end
    if (trap_go) begin
      next_psw[PSW_IE_BIT] = 1'b0;
    end
    if (ack_go) begin
      next_psw[PSW_IE_BIT]  = 1'b0;
      next_psw[PSW_ISP_BIT] = i_priority_flag[win_idx];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_psw <= PSW_RESET;
    end else begin
      o_psw <= next_psw;
    end
  end

  // save and vector sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state       <= ST_IDLE;
      trap_active <= 1'b0;
      pc_hold     <= 16'h0000;
      vec_hold    <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trap_go) begin
            state       <= ST_PUSH_STATUS_OP;
            trap_active <= 1'b1;
            pc_hold     <= i_pc;
            vec_hold    <= TRAP_VECTOR;
          end else if (ack_go) begin
            state       <= ST_PUSH_STATUS_OP;
            trap_active <= 1'b0;
            pc_hold     <= i_pc;
            vec_hold    <= EXT_VECTOR_BASE + 16'(win_idx) * EXT_VECTOR_STEP;
          end
        end
        ST_PUSH_STATUS_OP: state <= ST_PUSH_PCH;
        ST_PUSH_PCH: state <= ST_PUSH_PCL;
        ST_PUSH_PCL: state <= ST_VECTOR;
        ST_VECTOR:   state <= ST_IDLE;
        default:     state <= ST_IDLE;
      endcase
    end
  end

  // stack strobe: status word first (psw before ie clear), then pc high, pc low
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_stack_wr   <= 1'b0;
      o_stack_data <= 8'h00;
    end else if (trap_go || ack_go) begin
      o_stack_wr   <= 1'b1;
      o_stack_data <= o_psw;
    end else if (state == ST_PUSH_STATUS_OP) begin
      o_stack_wr   <= 1'b1;
      o_stack_data <= pc_hold[15:8];
    end else if (state == ST_PUSH_PCH) begin
      o_stack_wr   <= 1'b1;
      o_stack_data <= pc_hold[7:0];
    end else if (i_push_status_op && state == ST_IDLE) begin
      o_stack_wr   <= 1'b1;
      o_stack_data <= o_psw;
    end else begin
      o_stack_wr   <= 1'b0;
      o_stack_data <= 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_vector_load <= 1'b0;
      o_vector_addr <= 16'h0000;
    end else if (state == ST_PUSH_PCL) begin
      o_vector_load <= 1'b1;
      o_vector_addr <= vec_hold;
    end else begin
      o_vector_load <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= trap_go || ack_go || (state != ST_IDLE && state != ST_VECTOR);
    end
  end

  // checks
  sequence s_save_path;
    o_stack_wr ##1 o_stack_wr ##1 o_stack_wr ##1 o_vector_load;
  endsequence

  chk_reset_edge_sel: assert property (@(posedge i_clk)
    !i_rst_b |=> rise_sel == 8'h00 && fall_sel == 8'h00)
    else $error("edge select not cleared by reset");

  chk_reset_psw_val: assert property (@(posedge i_clk)
    !i_rst_b |=> o_psw == 8'h02)
    else $error("status word not 02h after reset");

  chk_ack_needs_ie: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ack_go |-> o_psw[PSW_IE_BIT])
    else $error("maskable acknowledge with enable clear");

  chk_ack_eligible_src: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ack_go |-> o_request_flag[win_idx] && !i_mask_flag[win_idx])
    else $error("acknowledged source not eligible");

  chk_isp_blocks_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ack_go && !o_psw[PSW_ISP_BIT] |-> !i_priority_flag[win_idx])
    else $error("low priority taken during high priority service");

  chk_ack_save_order: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ack_go |=> o_stack_data == $past(o_psw) ##0 s_save_path)
    else $error("save order or vector timing wrong");

  chk_ack_clears_ie: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ack_go |=> !o_psw[PSW_IE_BIT] && o_psw[PSW_ISP_BIT] == $past(i_priority_flag[win_idx]))
    else $error("enable or in-service flag wrong after acknowledge");

  chk_trap_vector_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    trap_go |-> ##4 o_vector_load && o_vector_addr == 16'h003E)
    else $error("software interrupt did not vector to 003Eh");

  chk_min_latency_hi: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ack_go && !i_priority_flag[win_idx] |-> age[win_idx] >= 6'h03)
    else $error("high priority acknowledged too early");

  chk_pop_restores: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_pop_status_op && !ack_go && !trap_go |=> o_psw == $past(i_pop_data))
    else $error("status word not restored by pop");
endmodule // eiea_top

//--- inc/eiea_pkg.sv
// constants and types shared by the external interrupt edge and acknowledge logic
// assumes a cpu core that reports instruction boundaries and consumes stack and vector strobes
package eiea_pkg;
  localparam int          NUM_EXT          = 8;
  localparam logic [15:0] ADDR_RISE_SEL    = 16'hFF48;
  localparam logic [15:0] ADDR_FALL_SEL    = 16'hFF49;
  localparam logic [7:0]  EDGE_SEL_RESET   = 8'h00;
  localparam logic [7:0]  PSW_RESET        = 8'h02;
  localparam int          PSW_IE_BIT       = 7;
  localparam int          PSW_ISP_BIT      = 1;
  localparam int          MIN_CLK_HI       = 7;
  localparam int          MAX_CLK_HI       = 32;
  localparam int          MIN_CLK_LO       = 8;
  localparam int          MAX_CLK_LO       = 33;
  localparam int          SEQ_LEN          = 4;
  localparam int          AGE_W            = 6;
  localparam logic [5:0]  LEAD_HI          = 6'(MIN_CLK_HI - SEQ_LEN);
  localparam logic [5:0]  LEAD_LO          = 6'(MIN_CLK_LO - SEQ_LEN);
  localparam logic [5:0]  AGE_MAX          = 6'h3F;
  localparam logic [15:0] TRAP_VECTOR      = 16'h003E;
  localparam logic [15:0] EXT_VECTOR_BASE  = 16'h0006;
  localparam logic [15:0] EXT_VECTOR_STEP  = 16'h0002;

  // gray codes along the save path
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_PUSH_STATUS_OP = 3'b001,
    ST_PUSH_PCH = 3'b011,
    ST_PUSH_PCL = 3'b010,
    ST_VECTOR   = 3'b110
  } eiea_state_type;
endpackage

//--- test/eiea_core_model.sv
// cpu core stand-in: instruction boundaries, program counter, stack memory
// assumes the block strobes stack bytes and vector loads from i_clk rising edges
`timescale 1ns/1ps
module eiea_core_model
  import eiea_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [2:0]  i_gap,
  input  wire logic        i_busy,
  input  wire logic        i_stack_wr,
  input  wire logic [7:0]  i_stack_data,
  input  wire logic        i_vector_load,
  input  wire logic [15:0] i_vector_addr,
  input  wire logic        i_ret,
  input  wire logic        i_pop1,
  output logic             o_instr_end,
  output logic      [15:0] o_pc,
  output logic      [7:0]  o_pop_data
);
  logic [7:0] mem [0:15];
  logic [3:0] sp;
  logic [2:0] cnt;
  // a return unwinds pc low, pc high, then the status byte
  assign o_pop_data = i_ret ? mem[sp - 4'h3] : mem[sp - 4'h1];
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sp <= 4'h0;
    end else if (i_stack_wr) begin
      mem[sp] <= i_stack_data;
      sp      <= sp + 4'h1;
    end else if (i_ret) begin
      sp <= sp - 4'h3;
    end else if (i_pop1) begin
      sp <= sp - 4'h1;
    end
  end
  // no boundaries while state is saved, as a stalled core would behave
  always @(negedge i_clk) begin
    if (!i_rst_b) begin
      cnt         <= 3'h0;
      o_instr_end <= 1'b0;
      o_pc        <= 16'h1234;
    end else if (i_vector_load) begin
      cnt         <= 3'h0;
      o_instr_end <= 1'b0;
      o_pc        <= i_vector_addr;
    end else if (i_busy) begin
      o_instr_end <= 1'b0;
    end else begin
      if (o_instr_end) o_pc <= o_pc + 16'h0001;
      o_instr_end <= (cnt + 3'h1 >= i_gap);
      cnt         <= (cnt + 3'h1 >= i_gap) ? 3'h0 : cnt + 3'h1;
    end
  end
endmodule // eiea_core_model

//--- test/eiea_top_tb.sv
// self-checking bench for the edge select, status word and acknowledge logic
// assumes the core stand-in supplies boundaries, pc and popped stack bytes
`timescale 1ns/1ps
module eiea_top_tb
  import eiea_pkg::*;
;
  logic        clk, rst_b, mem_wr, mem_rd, bit_op, bit_val, psw_wr, psw_bit_op, div_busy;
  logic [7:0]  pins, mask, prio, req_clr, wdata, psw_wdata;
  logic [15:0] addr;
  logic [2:0]  bit_idx, gap;
  logic [6:0]  ops;
  logic        instr_end, stk_wr, vld, busy;
  logic [15:0] pc, vaddr, vlast, bpc;
  logic [7:0]  pop_data, rdata, program_status_word, rflag, stk_data;
  logic [7:0]  slog [0:2];
  int          err_count = 0, cmp_count = 0, cyc = 0, vcnt = 0, vcyc = 0, iecnt = 0, n, fcyc;
  int          bcnt = 0;

  eiea_top DUT (.i_clk(clk), .i_rst_b(rst_b), .i_ext_pins(pins), .i_mask_flag(mask),
    .i_priority_flag(prio), .i_req_clr(req_clr), .i_mem_wr(mem_wr), .i_mem_rd(mem_rd),
    .i_mem_addr(addr), .i_mem_wdata(wdata), .i_mem_bit_op(bit_op), .i_mem_bit_val(bit_val),
    .i_mem_bit_idx(bit_idx), .i_psw_wr(psw_wr), .i_psw_wdata(psw_wdata),
    .i_psw_bit_op(psw_bit_op), .i_psw_bit_val(bit_val), .i_psw_bit_idx(bit_idx),
    .i_enable_irq_op(ops[0]), .i_disable_irq_op(ops[1]), .i_soft_trap_op(ops[2]),
    .i_irq_return_op(ops[3]), .i_trap_return_op(ops[4]), .i_push_status_op(ops[5]),
    .i_pop_status_op(ops[6]), .i_pop_data(pop_data), .i_instr_end(instr_end),
    .i_div_busy(div_busy), .i_pc(pc), .o_mem_rdata(rdata), .o_psw(program_status_word),
    .o_request_flag(rflag), .o_stack_wr(stk_wr), .o_stack_data(stk_data),
    .o_vector_load(vld), .o_vector_addr(vaddr), .o_busy(busy));

  eiea_core_model core (.i_clk(clk), .i_rst_b(rst_b), .i_gap(gap), .i_busy(busy),
    .i_stack_wr(stk_wr), .i_stack_data(stk_data), .i_vector_load(vld),
    .i_vector_addr(vaddr), .i_ret(ops[3] | ops[4]), .i_pop1(ops[6]),
    .o_instr_end(instr_end), .o_pc(pc), .o_pop_data(pop_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // passive log of stack bytes, vectors and boundaries
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (instr_end) iecnt <= iecnt + 1;
    if (busy) bcnt <= bcnt + 1;
    if (instr_end) bpc <= pc;
    if (stk_wr) slog <= '{slog[1], slog[2], stk_data};
    if (vld) begin
      vcnt  <= vcnt + 1;
      vcyc  <= cyc;
      vlast <= vaddr;
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int k = 1);
    repeat (k) @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
                    input logic [2:0] i = 3'h0);
    addr    = a;
    wdata   = d;
    bit_op  = b;
    bit_val = d[0];
    bit_idx = i;
    mem_wr  = 1'b1;
    tick();
    mem_wr  = 1'b0;
    bit_op  = 1'b0;
    // let an edge pass so a following call never re-raises the strobe in this step
    tick();
  endtask

  task automatic rd(input string nm, input logic [15:0] a, input logic [7:0] e);
    addr   = a;
    mem_rd = 1'b1;
    tick();
    mem_rd = 1'b0;
    chk(nm, {8'h00, e}, {8'h00, rdata});
    tick();
  endtask

  task automatic pw(input logic [7:0] d, input logic b = 1'b0);
    psw_wdata  = d;
    bit_val    = d[0];
    bit_idx    = 3'h7;
    psw_wr     = ~b;
    psw_bit_op = b;
    tick();
    psw_wr     = 1'b0;
    psw_bit_op = 1'b0;
  endtask

  // one-cycle op: 0 en 1 dis 2 trap 3 irq ret 4 trap ret 5 push 6 pop
  task automatic op(input int k);
    ops = 7'(1 << k);
    tick();
    ops = 7'h00;
  endtask

  task automatic wait_vec(input logic [15:0] ev);
    int n0;
    n0 = vcnt;
    for (int i = 0; i < 60 && vcnt == n0; i++) tick();
    if (vcnt == n0) begin
      err_count++;
      $display("ERROR vector wait expected %h seen none", ev);
      tally_and_finish();
    end else begin
      chk("vector", ev, vlast);
    end
  endtask

  task automatic edge_pins(input logic [7:0] p, input logic [7:0] m, input logic [7:0] r);
    pins = 8'h00;
    mask = 8'hFF;
    tick(3);
    prio = r;
    pins = p;
    tick(4);
    mask = m;
  endtask

  initial begin
    {rst_b, mem_wr, mem_rd, bit_op, bit_val, psw_wr, psw_bit_op, div_busy} = '0;
    {pins, req_clr, wdata, psw_wdata, addr, bit_idx, ops} = '0;
    {mask, prio, gap} = {8'hFF, 8'hFF, 3'h2};
    tick(10);
    rst_b = 1'b1;
    rd("rise sel reset", ADDR_RISE_SEL, EDGE_SEL_RESET);
    rd("fall sel reset", ADDR_FALL_SEL, EDGE_SEL_RESET);
    chk("psw reset", {8'h00, PSW_RESET}, {8'h00, program_status_word});
    wr(ADDR_RISE_SEL, 8'hA5);
    wr(ADDR_FALL_SEL, 8'h5A);
    wr(16'hFF50, 8'h11);
    rd("rise sel byte", ADDR_RISE_SEL, 8'hA5);
    rd("fall sel byte", ADDR_FALL_SEL, 8'h5A);
    rd("unmapped", 16'hFF50, 8'h00);
    wr(ADDR_RISE_SEL, 8'h01, 1'b1, 3'h1);
    wr(ADDR_FALL_SEL, 8'h00, 1'b1, 3'h6);
    rd("rise sel bit", ADDR_RISE_SEL, 8'hA7);
    rd("fall sel bit", ADDR_FALL_SEL, 8'h1A);
    $display("test registers done");
    // pin n gets mode n mod 4: off, fall, rise, both
    wr(ADDR_RISE_SEL, 8'hCC);
    wr(ADDR_FALL_SEL, 8'hAA);
    pins = 8'hFF;
    tick(3);
    chk("rise flags", 16'h00CC, {8'h00, rflag});
    req_clr = 8'hFF;
    tick();
    req_clr = 8'h00;
    tick(3);
    chk("cleared flags", 16'h0000, {8'h00, rflag});
    pins = 8'h00;
    tick(3);
    chk("fall flags", 16'h00AA, {8'h00, rflag});
    wr(ADDR_RISE_SEL, 8'h00);
    wr(ADDR_FALL_SEL, 8'h00);
    req_clr = 8'hFF;
    tick();
    req_clr = 8'h00;
    pins = 8'h55;
    tick(3);
    chk("detect off", 16'h0000, {8'h00, rflag});
    $display("test edges done");
    pw(8'h40);
    chk("psw byte", 16'h0040, {8'h00, program_status_word});
    pw(8'h01, 1'b1);
    chk("psw bit", 16'h00C0, {8'h00, program_status_word});
    op(1);
    chk("psw disable", 16'h0040, {8'h00, program_status_word});
    tick();
    op(0);
    chk("psw enable", 16'h00C0, {8'h00, program_status_word});
    pw(8'h02);
    $display("test status word done");
    wr(ADDR_RISE_SEL, 8'hFF);
    op(0);
    edge_pins(8'h04, 8'hFF, 8'h00);
    tick(40);
    chk("masked held", 16'h0004, {8'h00, rflag});
    chk("no vector masked", 16'h0000, 16'(vcnt));
    mask = 8'hFB;
    wait_vec(16'h000A);
    // save sequence keeps the core stalled for psw, pc high, pc low and vector
    chk("busy cycles", 16'h0004, 16'(bcnt));
    chk("saved psw", 16'h0082, {8'h00, slog[0]});
    chk("saved pc", bpc, {slog[1], slog[2]});
    chk("psw at ack", 16'h0000, {8'h00, program_status_word});
    op(3);
    chk("psw irq return", 16'h0082, {8'h00, program_status_word});
    edge_pins(8'h04, 8'hFB, 8'h00);
    fcyc = cyc - 3;
    wait_vec(16'h000A);
    n = (vcyc - fcyc >= MIN_CLK_HI) && (vcyc - fcyc <= MAX_CLK_HI);
    chk("hi latency", 16'h0001, 16'(n));
    op(3);
    $display("test acknowledge done");
    edge_pins(8'h60, 8'h9F, 8'h20);
    wait_vec(16'h0012);
    op(0);
    tick(40);
    chk("low refused", 16'h0012, vlast);
    op(3);
    n = iecnt;
    wait_vec(16'h0010);
    chk("boundary first", 16'h0001, 16'(iecnt - n >= 2));
    chk("psw low ack", 16'h0002, {8'h00, program_status_word});
    op(3);
    edge_pins(8'h0A, 8'hF5, 8'h00);
    wait_vec(16'h0008);
    op(3);
    wait_vec(16'h000C);
    op(3);
    $display("test priority done");
    div_busy = 1'b1;
    edge_pins(8'h01, 8'hFE, 8'h00);
    tick(40);
    chk("divide holds", 16'h000C, vlast);
    div_busy = 1'b0;
    wait_vec(16'h0006);
    op(3);
    tick();
    op(2);
    wait_vec(TRAP_VECTOR);
    chk("trap saved psw", 16'h0082, {8'h00, slog[0]});
    chk("psw trap", 16'h0002, {8'h00, program_status_word});
    op(2);
    wait_vec(TRAP_VECTOR);
    op(4);
    chk("psw trap ret", 16'h0002, {8'h00, program_status_word});
    tick();
    op(4);
    chk("psw trap ret2", 16'h0082, {8'h00, program_status_word});
    $display("test trap done");
    pw(8'h81);
    op(5);
    tick(2);
    chk("pushed psw", 16'h0081, {8'h00, slog[2]});
    pw(8'h00);
    op(6);
    chk("popped psw", 16'h0081, {8'h00, program_status_word});
    $display("test push pop done");
    tally_and_finish();
  end
endmodule // eiea_top_tb
